//--- pkg/diag_cfg.svh
`ifndef DIAG_CFG_SVH
`define DIAG_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_OUT2_NEG_HIGH 8'h68
`define OFS_OUT2_NEG_LOW 8'h69
`define OFS_TEMPERATURE_HIGH 8'h6a
`define OFS_TEMPERATURE_LOW 8'h6b
`define OFS_BIAS_LOAD_HIGH 8'h6c
`define OFS_BIAS_LOAD_LOW 8'h6d
`define OFS_ANALOG_SUPPLY_HIGH 8'h6e
`define OFS_ANALOG_SUPPLY_LOW 8'h6f
`define OFS_AUX_INPUT_HIGH 8'h70
`define OFS_AUX_INPUT_LOW 8'h71
`define OFS_STEP_UP_CONVERTER_CONFIG 8'h72

// ----------------------------------------
// Channel identifiers, low nibble of each low register
// ----------------------------------------
`define CHAN_ID_OUT2_NEG 4'h9
`define CHAN_ID_TEMPERATURE 4'ha
`define CHAN_ID_BIAS_LOAD 4'hb
`define CHAN_ID_ANALOG_SUPPLY 4'hc
`define CHAN_ID_AUX_INPUT 4'hd

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SOURCE_COUNT 5
`define BIT_CONVERTER_BYPASS 7
`define BIT_CONVERTER_OVERCURRENT_GUARD_OFF 6
`define BIT_CONVERTER_KEEP_ON_FAULT 5
`define RST_RESULT 12'h000
`define RST_STEP_UP_CONFIG 8'h00
`define RST_READ_DATA 8'h00
`define UNMAPPED_READ_DATA 8'h00

`endif

//--- pkg/diag_pkg.sv
package diag_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [11:0] result_type;
  typedef logic [7:0] byte_type;

  typedef enum logic [2:0]
  {
    SRC_OUT2_NEG = 3'h0,
    SRC_TEMPERATURE = 3'h1,
    SRC_BIAS_LOAD = 3'h2,
    SRC_ANALOG_SUPPLY = 3'h3,
    SRC_AUX_INPUT = 3'h4
  } source_type;

endpackage

//--- pkg/result_if.sv
`include "diag_cfg.svh"

interface result_if;
  import diag_pkg::*;

  result_type result_word [`SOURCE_COUNT];

  modport producer (output result_word);
  modport consumer (input result_word);
endinterface

//--- sim/diag_monitor.sv
module diag_monitor import diag_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID,
  // Monitor and converter
  input wire logic MON_VALID,
  input wire source_type MON_SEL,
  input wire result_type MON_DATA,
  input wire logic BIAS_FAULT_PD,
  input wire logic CONV_BYPASS,
  input wire logic CONV_OCP_ACTIVE,
  input wire logic CONV_POWER_ON
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_chan_id:
    assert property (REG_RD && REG_ADDR inside {8'h69, 8'h6b, 8'h6d, 8'h6f, 8'h71}
      |=> REG_RDATA[3:0] == 4'(($past(REG_ADDR) - 8'h69) / 8'h02 + 8'h09))
    else $error("channel id wrong");
  a_high_byte:
    assert property (MON_VALID && MON_SEL == SRC_TEMPERATURE ##1 (!MON_VALID [*4])
      ##0 (REG_RD && REG_ADDR == 8'h6a) |=> REG_RDATA == $past(MON_DATA[11:4], 5))
    else $error("high byte wrong");
  a_low_nibble:
    assert property (MON_VALID && MON_SEL == SRC_BIAS_LOAD ##1 !MON_VALID
      ##1 (REG_RD && REG_ADDR == 8'h6d) |=> REG_RDATA[7:4] == $past(MON_DATA[3:0], 3))
    else $error("low nibble wrong");
  a_reserved_zero:
    assert property (REG_RD && REG_ADDR == 8'h72 |=> REG_RDATA[4:0] == 5'h00)
    else $error("reserved bits not zero");
  a_config_readback:
    assert property (REG_WR && REG_ADDR == 8'h72 ##1 !REG_WR ##1 (REG_RD && REG_ADDR == 8'h72)
      |=> REG_RDATA[7:5] == $past(REG_WDATA[7:5], 3))
    else $error("config readback wrong");
  a_bypass_follows:
    assert property (REG_WR && REG_ADDR == 8'h72 |=> ##1 CONV_BYPASS == $past(REG_WDATA[7], 2))
    else $error("bypass wrong");
  a_guard_follows:
    assert property (REG_WR && REG_ADDR == 8'h72
      |=> ##1 CONV_OCP_ACTIVE == !$past(REG_WDATA[6], 2))
    else $error("overcurrent guard wrong");
  a_fault_powers_down:
    assert property (REG_WR && REG_ADDR == 8'h72 && REG_WDATA[7:5] == 3'h0
      ##1 (BIAS_FAULT_PD && !REG_WR) [*4] |=> !CONV_POWER_ON)
    else $error("converter kept on during fault");
  a_reset_state:
    assert property ($fell(RST) |-> !REG_RVALID && REG_RDATA == 8'h00 && !CONV_BYPASS
      && CONV_OCP_ACTIVE && CONV_POWER_ON)
    else $error("reset state wrong");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  cover property ($fell(RST));
  cover property (MON_VALID && MON_SEL == SRC_AUX_INPUT);
  cover property (REG_WR && REG_ADDR == 8'h72 && REG_WDATA[7]);
endmodule

bind diag_monitor_readback_regs diag_monitor diag_monitor_inst (.MCLK(MCLK), .RST(RST),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .MON_VALID(MON_VALID),
  .MON_SEL(MON_SEL), .MON_DATA(MON_DATA), .BIAS_FAULT_PD(BIAS_FAULT_PD),
  .CONV_BYPASS(CONV_BYPASS), .CONV_OCP_ACTIVE(CONV_OCP_ACTIVE),
  .CONV_POWER_ON(CONV_POWER_ON));

//--- sim/testbench.sv
module testbench import diag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK = 1'b0;
  logic RST, REG_WR, REG_RD, MON_VALID, BIAS_FAULT_PD, REG_RVALID;
  logic CONV_BYPASS, CONV_OCP_ACTIVE, CONV_POWER_ON;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, d;
  source_type MON_SEL;
  result_type MON_DATA, v;
  int miscompares, n_checks;

  always #50 MCLK = ~MCLK;

  diag_monitor_readback_regs diag_monitor_readback_regs_inst (.MCLK(MCLK), .RST(RST),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .MON_VALID(MON_VALID),
    .MON_SEL(MON_SEL), .MON_DATA(MON_DATA), .BIAS_FAULT_PD(BIAS_FAULT_PD),
    .CONV_BYPASS(CONV_BYPASS), .CONV_OCP_ACTIVE(CONV_OCP_ACTIVE),
    .CONV_POWER_ON(CONV_POWER_ON));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic result_type val(input int s);
    return 12'hf1e - 12'(s) * 12'h123;
  endfunction

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_WDATA <= w;
    REG_WR <= 1'b1;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask

  // Read data only counts when the valid pulse came on time
  task rd(input logic [7:0] a);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1;
    d = REG_RVALID === 1'b1 ? REG_RDATA : 8'hxx;
  endtask

  task conv_is(input logic [7:0] exp);
    repeat (4) @(posedge MCLK);
    #1;
    chk({5'h00, CONV_BYPASS, CONV_OCP_ACTIVE, CONV_POWER_ON}, exp);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    for (int s = 0; s < 5; s++)
    begin
      rd(8'h68 + 8'(2 * s));
      chk(d, 8'h00);
      rd(8'h69 + 8'(2 * s));
      chk(d, {4'h0, 4'h9 + 4'(s)});
    end
    rd(8'h72);
    chk(d, 8'h00);
    conv_is(8'h03);
    $display("reset test done");
  endtask

  // Low register read first so the high read lands later
  task t_results;
    for (int s = 0; s < 5; s++)
    begin
      @(posedge MCLK);
      MON_VALID <= 1'b1;
      MON_SEL <= source_type'(s);
      MON_DATA <= val(s);
      @(posedge MCLK);
      MON_VALID <= 1'b0;
      v = val(s);
      rd(8'h69 + 8'(2 * s));
      chk(d, {v[3:0], 4'h9 + 4'(s)});
      rd(8'h68 + 8'(2 * s));
      chk(d, v[11:4]);
    end
    $display("result test done");
  endtask

  task t_read_only;
    // Codes 5 and up are dropped, so every stored result must survive
    @(posedge MCLK);
    MON_VALID <= 1'b1;
    MON_SEL <= source_type'(3'h5);
    MON_DATA <= 12'h000;
    @(posedge MCLK);
    MON_VALID <= 1'b0;
    for (int s = 0; s < 5; s++)
    begin
      v = val(s);
      wr(8'h68 + 8'(2 * s), 8'hff);
      wr(8'h69 + 8'(2 * s), 8'h00);
      rd(8'h68 + 8'(2 * s));
      chk(d, v[11:4]);
      rd(8'h69 + 8'(2 * s));
      chk(d, {v[3:0], 4'h9 + 4'(s)});
    end
    $display("read-only test done");
  endtask

  // Software keeps reserved bits at zero on every write
  task t_config;
    wr(8'h72, 8'he0);
    rd(8'h72);
    chk(d, 8'he0);
    conv_is(8'h04);
    @(posedge MCLK);
    BIAS_FAULT_PD <= 1'b1;
    wr(8'h72, 8'h20);
    conv_is(8'h03);
    wr(8'h72, 8'h00);
    conv_is(8'h02);
    @(posedge MCLK);
    BIAS_FAULT_PD <= 1'b0;
    wr(8'h72, 8'h40);
    conv_is(8'h01);
    $display("config test done");
  endtask

  task results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    {RST, REG_WR, REG_RD, MON_VALID, BIAS_FAULT_PD} = 5'h10;
    {REG_ADDR, REG_WDATA, MON_DATA} = 28'h0;
    MON_SEL = SRC_OUT2_NEG;
    repeat (6) @(posedge MCLK);
    RST <= 1'b0;
    t_reset;
    t_results;
    t_read_only;
    t_config;
    // Mid-run reset must clear results and config again
    @(posedge MCLK);
    RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    t_reset;
    results;
  end
endmodule

//--- verilog/diag_monitor_readback_regs.sv

`include "diag_cfg.svh"

module diag_monitor_readback_regs import diag_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  // Monitor results
  input wire logic MON_VALID,
  input wire source_type MON_SEL,
  input wire result_type MON_DATA,
  // Converter control
  input wire logic BIAS_FAULT_PD,
  output logic CONV_BYPASS,
  output logic CONV_OCP_ACTIVE,
  output logic CONV_POWER_ON
);

  // ----------------------------------------
  // Byte formatting
  // ----------------------------------------
  function automatic byte_type high_byte(input result_type r);
    high_byte = r[11:4];
  endfunction

  function automatic byte_type low_byte(input result_type r, input logic [3:0] id);
    low_byte = {r[3:0], id};
  endfunction

  // ----------------------------------------
  // Result store
  // ----------------------------------------
  result_if res ();

  result_capture u_capture
  (
    .clk(MCLK),
    .rst(RST),
    .mon_valid(MON_VALID),
    .mon_sel(MON_SEL),
    .mon_data(MON_DATA),
    .res(res.producer)
  );

  // ----------------------------------------
  // Fault input synchroniser
  // ----------------------------------------
  logic fault_meta_ff;
  logic fault_sync_ff;
  logic nxt_fault_meta;
  logic nxt_fault_sync;

  always_comb
  begin
    nxt_fault_meta = BIAS_FAULT_PD;
    nxt_fault_sync = fault_meta_ff;
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      fault_meta_ff <= 1'b0;
      fault_sync_ff <= 1'b0;
    end
    else
    begin
      fault_meta_ff <= nxt_fault_meta;
      fault_sync_ff <= nxt_fault_sync;
    end
  end

  // ----------------------------------------
  // Converter configuration register
  // ----------------------------------------
  logic bypass_ff;
  logic guard_off_ff;
  logic keep_on_ff;
  logic nxt_bypass;
  logic nxt_guard_off;
  logic nxt_keep_on;

  always_comb
  begin
    nxt_bypass = bypass_ff;
    nxt_guard_off = guard_off_ff;
    nxt_keep_on = keep_on_ff;
    // Reserved bits 4-0 are dropped on write; only 7-5 are stored
    if (REG_WR && (REG_ADDR == `OFS_STEP_UP_CONVERTER_CONFIG))
    begin
      nxt_bypass = REG_WDATA[`BIT_CONVERTER_BYPASS];
      nxt_guard_off = REG_WDATA[`BIT_CONVERTER_OVERCURRENT_GUARD_OFF];
      nxt_keep_on = REG_WDATA[`BIT_CONVERTER_KEEP_ON_FAULT];
    end
  end

  // A literal cannot be bit-selected, so the reset word gets a name
  localparam byte_type rst_config = `RST_STEP_UP_CONFIG;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      bypass_ff <= rst_config[`BIT_CONVERTER_BYPASS];
      guard_off_ff <= rst_config[`BIT_CONVERTER_OVERCURRENT_GUARD_OFF];
      keep_on_ff <= rst_config[`BIT_CONVERTER_KEEP_ON_FAULT];
    end
    else
    begin
      bypass_ff <= nxt_bypass;
      guard_off_ff <= nxt_guard_off;
      keep_on_ff <= nxt_keep_on;
    end
  end

  // ----------------------------------------
  // Converter control outputs
  // ----------------------------------------
  logic conv_bypass_ff;
  logic conv_ocp_active_ff;
  logic conv_power_on_ff;
  logic nxt_conv_bypass;
  logic nxt_conv_ocp_active;
  logic nxt_conv_power_on;

  always_comb
  begin
    nxt_conv_bypass = bypass_ff;
    nxt_conv_ocp_active = ~guard_off_ff;
    // A bias fault only stops the converter when keep-on is clear
    nxt_conv_power_on = ~bypass_ff & ~(fault_sync_ff & ~keep_on_ff);
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      conv_bypass_ff <= 1'b0;
      conv_ocp_active_ff <= 1'b1;
      conv_power_on_ff <= 1'b1;
    end
    else
    begin
      conv_bypass_ff <= nxt_conv_bypass;
      conv_ocp_active_ff <= nxt_conv_ocp_active;
      conv_power_on_ff <= nxt_conv_power_on;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  byte_type rdata_ff;
  logic rvalid_ff;
  byte_type nxt_rdata;
  logic nxt_rvalid;
  byte_type read_word;

  always_comb
  begin
    unique case (REG_ADDR)
      `OFS_OUT2_NEG_HIGH:
      begin
        read_word = high_byte(res.result_word[SRC_OUT2_NEG]);
      end
      `OFS_OUT2_NEG_LOW:
      begin
        read_word = low_byte(res.result_word[SRC_OUT2_NEG], `CHAN_ID_OUT2_NEG);
      end
      `OFS_TEMPERATURE_HIGH:
      begin
        read_word = high_byte(res.result_word[SRC_TEMPERATURE]);
      end
      `OFS_TEMPERATURE_LOW:
      begin
        read_word = low_byte(res.result_word[SRC_TEMPERATURE], `CHAN_ID_TEMPERATURE);
      end
      `OFS_BIAS_LOAD_HIGH:
      begin
        read_word = high_byte(res.result_word[SRC_BIAS_LOAD]);
      end
      `OFS_BIAS_LOAD_LOW:
      begin
        read_word = low_byte(res.result_word[SRC_BIAS_LOAD], `CHAN_ID_BIAS_LOAD);
      end
      `OFS_ANALOG_SUPPLY_HIGH:
      begin
        read_word = high_byte(res.result_word[SRC_ANALOG_SUPPLY]);
      end
      `OFS_ANALOG_SUPPLY_LOW:
      begin
        read_word = low_byte(res.result_word[SRC_ANALOG_SUPPLY],
                             `CHAN_ID_ANALOG_SUPPLY);
      end
      `OFS_AUX_INPUT_HIGH:
      begin
        read_word = high_byte(res.result_word[SRC_AUX_INPUT]);
      end
      `OFS_AUX_INPUT_LOW:
      begin
        read_word = low_byte(res.result_word[SRC_AUX_INPUT], `CHAN_ID_AUX_INPUT);
      end
      `OFS_STEP_UP_CONVERTER_CONFIG:
      begin
        // Reserved bits always read back as zero
        read_word = {bypass_ff, guard_off_ff, keep_on_ff, 5'h00};
      end
      default:
      begin
        read_word = `UNMAPPED_READ_DATA;
      end
    endcase
  end

  always_comb
  begin
    nxt_rvalid = REG_RD;
    nxt_rdata = rdata_ff;
    // Data holds between reads so a slow reader sees a stable byte
    if (REG_RD)
    begin
      nxt_rdata = read_word;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      rdata_ff <= `RST_READ_DATA;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Monitor registers have no write path at all, so writes there are lost
  assign REG_RDATA = rdata_ff;
  assign REG_RVALID = rvalid_ff;
  assign CONV_BYPASS = conv_bypass_ff;
  assign CONV_OCP_ACTIVE = conv_ocp_active_ff;
  assign CONV_POWER_ON = conv_power_on_ff;

endmodule

//--- verilog/result_capture.sv
`include "diag_cfg.svh"

module result_capture import diag_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Conversion results from the monitor
  input wire logic mon_valid,
  input wire source_type mon_sel,
  input wire result_type mon_data,
  // Stored results
  result_if.producer res
);

  // ----------------------------------------
  // Result store
  // ----------------------------------------
  result_type result_ff [`SOURCE_COUNT];
  result_type nxt_result [`SOURCE_COUNT];

  always_comb
  begin
    for (int i = 0; i < `SOURCE_COUNT; i++)
    begin
      nxt_result[i] = result_ff[i];
    end
    // Codes above the last source are dropped, not wrapped
    if (mon_valid && (int'(mon_sel) < `SOURCE_COUNT))
    begin
      nxt_result[int'(mon_sel)] = mon_data;
    end
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < `SOURCE_COUNT; i++)
    begin
      if (rst)
      begin
        result_ff[i] <= `RST_RESULT;
      end
      else
      begin
        result_ff[i] <= nxt_result[i];
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < `SOURCE_COUNT; i++)
    begin
      res.result_word[i] = result_ff[i];
    end
  end

endmodule
